// file: common/ieb_pkg.sv
package ieb_pkg;
	// Field and address layout
	localparam int ADDR_W = 12; // Master and slave address width
	localparam int FLD_W = 13; // Address plus parity bit
	localparam int GRP_LSB = 8; // Group number sits above the unit number
	localparam int BYTE_W = 8; // Data bits per byte
	localparam logic [5:0] MAX_BYTES = 6'h20; // Largest data count per frame
	localparam logic [3:0] ADDR_BITS = 4'hd; // Bits in an address field
	localparam logic [3:0] BYTE_BITS = 4'h8; // Bits in a data field
	localparam logic [3:0] BCAST_BITS = 4'h1; // Bits in the broadcast field
	localparam logic [3:0] START_BITS = 4'h7; // Start bit length in bit periods
	localparam int CNT_W = 16; // Width of cycle counters

	// Timing, in its own unit and derived in clock cycles
	localparam int CLK_MHZ = 250; // Core clock rate
	localparam int BIT_TIME_NS = 26000; // Bit period of the supported mode
	localparam int BIT_CYC = (BIT_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int IDLE_BITS = 2; // Released bus time that marks idle
	localparam int IDLE_CYC = BIT_CYC * IDLE_BITS;

	// Frame sequencer states; the first one is the reset state
	typedef enum logic [2:0] {
		ST_WAIT,
		ST_IDLE,
		ST_START,
		ST_BCAST,
		ST_MADDR,
		ST_SADDR,
		ST_DATA
	} ieb_state_t;

	// Complete state of the controller
	typedef struct packed {
		ieb_state_t st;
		logic drive;
		logic tx_on;
		logic master;
		logic [3:0] bcnt;
		logic [FLD_W-1:0] sreg;
		logic [FLD_W-1:0] cap;
		logic [5:0] bytes_left;
		logic [CNT_W-1:0] idle_cnt;
		logic lost;
		logic done;
		logic rx_valid;
		logic rx_bcast;
		logic rx_grp_hit;
		logic rx_unit_hit;
		logic [ADDR_W-1:0] rx_maddr;
		logic [ADDR_W-1:0] rx_saddr;
	} ieb_core_t;

	// State of the bit timer
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} ieb_tmr_t;

	localparam ieb_core_t CORE_RST = '0; // All clear, state ST_WAIT
	localparam ieb_tmr_t TMR_RST = '0;
endpackage : ieb_pkg

// file: core/ieb_bit_timer.sv
`timescale 1ns/1ps
// Bit period divider: mid-bit sample pulse and end-of-bit pulse
module ieb_bit_timer import ieb_pkg::*; #(
	parameter int PERIOD = BIT_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_restart,
	output logic o_mid,
	output logic o_end
);
	ieb_tmr_t s_r; // Registered state
	ieb_tmr_t s_nxt; // Next state

	localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);
	localparam logic [CNT_W-1:0] MID = CNT_W'(PERIOD / 2);

	// Free run, realigned to a frame's first edge by restart
	always_comb begin
		s_nxt = s_r;
		if (i_restart || s_r.cnt == LAST) begin
			s_nxt.cnt = '0;
		end else begin
			s_nxt.cnt = s_r.cnt + 16'h0001;
		end
	end

	// State register
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			s_r <= TMR_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Pulses are decoded from the counter, gated off by a restart
	assign o_mid = (s_r.cnt == MID) && !i_restart;
	assign o_end = (s_r.cnt == LAST) && !i_restart;
endmodule : ieb_bit_timer

// file: core/ieb_arb.sv
`timescale 1ns/1ps
// Functional notes
// R01: Bus pins use active-low polarity
// R02: Any unit may start a transfer
// R03: Group and all-unit broadcasts supported
// R04: Only the mode 1 bit timing
// R05: Every unit on the bus shares one mode
// R06: Half duplex, no clock line
// R07: Collision arbitration leaves one master
// R08: Broadcast beats individual transfer
// R09: Lower twelve-bit master address wins
// R10: Abort gives up bus mastership
// R11: Address splits into group and unit
// R12: Broadcast bit zero, individual bit one
// R13: Bit mismatch stops sending, starts receiving
// R14: At most 32 data bytes per frame
// R15: Retry only after the bus is idle
// R16: Open-drain wired-AND drive of the bus
module ieb_arb import ieb_pkg::*; #(
	parameter int BIT_PERIOD = BIT_CYC, // Cycles per bit
	parameter int IDLE_PERIOD = IDLE_CYC // Released cycles that mark idle
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_bus_rx_n,
	output logic o_bus_tx_n,
	output logic o_bus_tx_oe,
	input wire logic i_tx_req,
	input wire logic i_tx_bcast,
	input wire logic [ADDR_W-1:0] i_own_addr,
	input wire logic [ADDR_W-1:0] i_slave_addr,
	input wire logic [5:0] i_tx_len,
	input wire logic [BYTE_W-1:0] i_tx_byte,
	input wire logic i_tx_byte_valid,
	output logic o_tx_byte_ready,
	input wire logic i_abort,
	output logic o_master,
	output logic o_lost,
	output logic o_done,
	output logic o_rx_valid,
	output logic o_rx_bcast,
	output logic o_rx_grp_hit,
	output logic o_rx_unit_hit,
	output logic [ADDR_W-1:0] o_rx_maddr,
	output logic [ADDR_W-1:0] o_rx_saddr
);
	ieb_core_t s_r; // Registered state
	ieb_core_t s_nxt; // Next state
	logic t_mid; // Mid-bit sample point
	logic t_end; // Bit boundary
	logic restart; // Realign bit timer to a start edge
	logic bus_rel; // Bus released, reads as logic one
	logic idle_ok; // Bus idle long enough to contend
	logic byte_take; // A data byte is taken this cycle
	logic last_bit; // Final bit of the current field
	logic [5:0] len_cap; // Requested length, clipped

	localparam logic [CNT_W-1:0] IDLE_C16 = CNT_W'(IDLE_PERIOD); // A released run this long inside a frame also reads as idle
	// Upper address bits name the group
	function automatic logic [ADDR_W-GRP_LSB-1:0] grp_of(input logic [ADDR_W-1:0] a);
		grp_of = a[ADDR_W-1:GRP_LSB];
	endfunction : grp_of
	// Lower address bits name the unit in its group
	function automatic logic [GRP_LSB-1:0] unit_of(input logic [ADDR_W-1:0] a);
		unit_of = a[GRP_LSB-1:0];
	endfunction : unit_of
	// States that move one bit per bit period
	function automatic logic is_field(input ieb_state_t st);
		is_field = (st == ST_BCAST) || (st == ST_MADDR) || (st == ST_SADDR) || (st == ST_DATA);
	endfunction : is_field
	// Bit count of the field in progress
	function automatic logic [3:0] field_len(input ieb_state_t st);
		unique case (st)
			ST_BCAST: field_len = BCAST_BITS;
			ST_MADDR, ST_SADDR: field_len = ADDR_BITS;
			ST_DATA: field_len = BYTE_BITS;
			default: field_len = BCAST_BITS;
		endcase
	endfunction : field_len
	// One timer serves start bit and data bits, so mode 1 timing only
	ieb_bit_timer #(
		.PERIOD(BIT_PERIOD)
	) u_bit_timer (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_restart(restart),
		.o_mid(t_mid),
		.o_end(t_end)
	); // [R04] [R05]
	// Released line reads high; dominant low wins the wired-AND
	assign bus_rel = i_bus_rx_n; // [R01]
	assign idle_ok = (s_r.idle_cnt == IDLE_C16);
	assign last_bit = (s_r.bcnt == field_len(s_r.st) - 4'h1);
	assign len_cap = (i_tx_len > MAX_BYTES) ? MAX_BYTES : i_tx_len; // [R14]

	// Frame sequencer: start, broadcast bit, addresses, data
	always_comb begin
		s_nxt = s_r;
		restart = 1'b0;
		byte_take = 1'b0;
		s_nxt.lost = 1'b0;
		s_nxt.done = 1'b0;
		s_nxt.rx_valid = 1'b0;
		// Idle watch: any dominant level restarts the count
		if (!bus_rel) begin
			s_nxt.idle_cnt = '0;
		end else if (!idle_ok) begin
			s_nxt.idle_cnt = s_r.idle_cnt + 16'h0001;
		end
		unique case (s_r.st)
			ST_WAIT: begin
				// Listen only until the line has gone quiet
				s_nxt.drive = 1'b0;
				s_nxt.tx_on = 1'b0;
				s_nxt.master = 1'b0;
				if (idle_ok) begin
					s_nxt.st = ST_IDLE; // [R15]
				end
			end
			ST_IDLE: begin
				if (!bus_rel) begin
					// Someone else began; a pending request joins without a start bit
					s_nxt.st = ST_START;
					restart = 1'b1;
					s_nxt.bcnt = 4'h0;
					s_nxt.tx_on = i_tx_req; // [R02] [R07]
					s_nxt.drive = 1'b0;
				end else if (i_tx_req && idle_ok) begin
					// Own start bit is a long dominant period
					s_nxt.st = ST_START;
					restart = 1'b1;
					s_nxt.bcnt = 4'h0;
					s_nxt.tx_on = 1'b1; // [R02] [R15]
					s_nxt.drive = 1'b1;
				end
			end
			ST_START: begin
				if (t_end) begin
					s_nxt.bcnt = s_r.bcnt + 4'h1;
					if (s_r.bcnt == START_BITS - 4'h1) begin
						// All contenders leave the start bit on the same edge
						s_nxt.st = ST_BCAST;
						s_nxt.bcnt = 4'h0;
						s_nxt.sreg = {~i_tx_bcast, 12'h000}; // [R12] [R08] [R03]
					end
				end
			end
			default: begin
				// Field states: sample mid-bit, compare against what was sent
				if (t_mid) begin
					s_nxt.cap = {s_r.cap[FLD_W-2:0], bus_rel};
					if (s_r.tx_on && (s_r.sreg[FLD_W-1] != bus_rel)) begin
						if (s_r.master) begin
							// Corruption after winning ends the frame
							s_nxt.st = ST_WAIT; // [R10]
							s_nxt.tx_on = 1'b0;
							s_nxt.master = 1'b0;
							s_nxt.drive = 1'b0;
						end else begin
							// Lost arbitration; stay on as a receiver
							s_nxt.tx_on = 1'b0; // [R13] [R09] [R07]
							s_nxt.drive = 1'b0;
							s_nxt.lost = 1'b1;
						end
					end
				end
				if (t_end) begin
					s_nxt.sreg = {s_r.sreg[FLD_W-2:0], 1'b1};
					s_nxt.bcnt = s_r.bcnt + 4'h1;
					if (last_bit) begin
						s_nxt.bcnt = 4'h0;
						unique case (s_r.st)
							ST_BCAST: begin
								s_nxt.st = ST_MADDR;
								s_nxt.rx_bcast = ~s_r.cap[0]; // [R12]
								s_nxt.sreg = {i_own_addr, ^i_own_addr}; // [R09]
							end
							ST_MADDR: begin
								// Only the lowest address survives twelve bits
								s_nxt.st = ST_SADDR;
								s_nxt.master = s_r.tx_on; // [R07]
								s_nxt.rx_maddr = s_r.cap[FLD_W-1:1];
								s_nxt.sreg = {i_slave_addr, ^i_slave_addr};
							end
							ST_SADDR: begin
								s_nxt.rx_saddr = s_r.cap[FLD_W-1:1];
								s_nxt.rx_valid = ~s_r.master; // [R06]
								s_nxt.rx_grp_hit = grp_of(s_r.cap[FLD_W-1:1]) == grp_of(i_own_addr); // [R11] [R03]
								s_nxt.rx_unit_hit = unit_of(s_r.cap[FLD_W-1:1]) == unit_of(i_own_addr); // [R11]
								if (!s_r.master) begin
									s_nxt.st = ST_WAIT; // [R15]
								end else if (len_cap == 6'h00) begin
									s_nxt.st = ST_WAIT;
									s_nxt.done = 1'b1;
									s_nxt.master = 1'b0;
									s_nxt.tx_on = 1'b0;
								end else begin
									byte_take = 1'b1;
									s_nxt.st = ST_DATA;
									s_nxt.bytes_left = len_cap - 6'h01; // [R14]
									s_nxt.sreg = {i_tx_byte, 5'h1f};
								end
							end
							ST_DATA: begin
								if (s_r.bytes_left == 6'h00) begin
									// Frame complete, mastership handed back
									s_nxt.st = ST_WAIT;
									s_nxt.done = 1'b1;
									s_nxt.master = 1'b0;
									s_nxt.tx_on = 1'b0;
								end else begin
									byte_take = 1'b1;
									s_nxt.bytes_left = s_r.bytes_left - 6'h01;
									s_nxt.sreg = {i_tx_byte, 5'h1f};
								end
							end
							default: begin
								s_nxt.st = ST_WAIT;
							end
						endcase
						// An empty source at a byte boundary aborts the frame
						if (byte_take && !i_tx_byte_valid) begin
							s_nxt.st = ST_WAIT; // [R10]
							s_nxt.master = 1'b0;
							s_nxt.tx_on = 1'b0;
						end
					end
				end
			end
		endcase
		// Software abort drops any transmission at once
		if (i_abort && s_r.tx_on) begin
			s_nxt.st = ST_WAIT; // [R10]
			s_nxt.tx_on = 1'b0;
			s_nxt.master = 1'b0;
		end
		// New bit: pull low for a zero, release for a one
		if (t_end && is_field(s_nxt.st)) begin
			s_nxt.drive = s_nxt.tx_on & ~s_nxt.sreg[FLD_W-1]; // [R16]
		end
		if (!s_nxt.tx_on) begin
			s_nxt.drive = 1'b0; // [R06]
		end
	end

	// State register
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			s_r <= CORE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Pin is only ever pulled low; release leaves the line to others
	assign o_bus_tx_n = 1'b0; // [R01] [R16]
	assign o_bus_tx_oe = s_r.drive;
	assign o_tx_byte_ready = byte_take;
	assign o_master = s_r.master;
	assign o_lost = s_r.lost;
	assign o_done = s_r.done;
	assign o_rx_valid = s_r.rx_valid;
	assign o_rx_bcast = s_r.rx_bcast;
	assign o_rx_grp_hit = s_r.rx_grp_hit;
	assign o_rx_unit_hit = s_r.rx_unit_hit;
	assign o_rx_maddr = s_r.rx_maddr;
	assign o_rx_saddr = s_r.rx_saddr;

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	chk_start_idle: assert property ($rose(o_bus_tx_oe) && s_r.st == ST_START |-> $past(idle_ok)) // [R15]
		else $error("start bit driven on a busy bus");
	chk_lose_release: assert property (o_lost |-> (!o_bus_tx_oe && !o_master) [*2]) // [R13]
		else $error("still driving after lost arbitration");
	chk_mismatch_stop: assert property (t_mid && is_field(s_r.st) && s_r.tx_on && !s_r.master
		&& s_r.sreg[FLD_W-1] != i_bus_rx_n && !i_abort |=> o_lost) // [R13]
		else $error("mismatch not flagged as lost");
	chk_abort_release: assert property (i_abort && s_r.tx_on |=> !o_master && !o_bus_tx_oe && s_r.st == ST_WAIT) // [R10]
		else $error("abort did not release the bus");
	chk_bcast_level: assert property (s_r.st == ST_START && t_end && s_r.bcnt == START_BITS - 4'h1
		&& s_r.tx_on && !i_abort |=> o_bus_tx_oe == $past(i_tx_bcast)) // [R12]
		else $error("broadcast bit level wrong");
	chk_bcast_wins: assert property (s_r.st == ST_BCAST && s_r.tx_on && !s_r.sreg[FLD_W-1] && t_mid |=> !o_lost) // [R08]
		else $error("broadcast sender lost at broadcast bit");
	chk_maddr_load: assert property (s_r.st == ST_BCAST && t_end && s_r.tx_on && !i_abort
		|=> s_r.sreg[FLD_W-1:1] == $past(i_own_addr)) // [R09]
		else $error("master address not loaded after broadcast bit");
	chk_len_cap: assert property (s_r.bytes_left <= MAX_BYTES) // [R14]
		else $error("byte count above frame limit");
	chk_half_dup: assert property (o_rx_valid |-> !o_master && !o_bus_tx_oe) // [R06]
		else $error("received frame while master");
	chk_drive_tx: assert property (o_bus_tx_oe |-> s_r.tx_on) // [R16]
		else $error("bus driven without a transmission");
	chk_done_free: assert property (o_done |-> s_r.st == ST_WAIT && !o_master ##1 !o_bus_tx_oe) // [R07]
		else $error("mastership kept after frame end");
endmodule : ieb_arb

// file: test/ieb_peer.sv
`timescale 1ns/1ps
// Another unit on the bus: sends one frame with one byte, backs off on a lost bit
module ieb_peer import ieb_pkg::*; #(
	parameter int BIT_PERIOD = 20 // Same bit timing as the device
) (
	input wire logic i_core_clk,
	input wire logic i_go,
	input wire logic i_bcast,
	input wire logic [ADDR_W-1:0] i_maddr,
	input wire logic [ADDR_W-1:0] i_saddr,
	input wire logic [BYTE_W-1:0] i_byte,
	input wire logic i_bus_rx_n,
	output logic o_bus_tx_oe,
	output logic o_busy,
	output logic o_lost,
	output logic [41:0] o_seen
);
	logic [41:0] sr_r; // Levels still to send, start bit first
	logic [15:0] cnt_r; // Cycle within the bit
	logic [5:0] idx_r; // Bit number in the frame
	initial begin
		o_busy = 1'b0;
		o_lost = 1'b0;
		o_seen = '0;
		sr_r = '1;
		cnt_r = '0;
		idx_r = '0;
	end
	// Bit engine; samples mid-bit, so a cycle of skew to the device is harmless
	always @(posedge i_core_clk) begin
		if (i_go && !o_busy) begin
			sr_r <= {7'h00, ~i_bcast, i_maddr, ^i_maddr, i_saddr, ^i_saddr, i_byte};
			cnt_r <= '0;
			idx_r <= '0;
			o_busy <= 1'b1;
			o_lost <= 1'b0;
		end else if (o_busy) begin
			cnt_r <= cnt_r + 16'h1;
			if (cnt_r == 16'(BIT_PERIOD / 2)) begin
				// Keep a copy of every level on the wire
				o_seen <= {o_seen[40:0], i_bus_rx_n};
				// Recessive sent but dominant seen in the contest bits: stop driving
				if (idx_r >= 6'h07 && idx_r <= 6'h13 && sr_r[41] && !i_bus_rx_n) begin
					o_lost <= 1'b1;
				end
			end
			if (cnt_r == 16'(BIT_PERIOD - 1)) begin
				cnt_r <= '0;
				sr_r <= {sr_r[40:0], 1'b1};
				idx_r <= idx_r + 6'h1;
				if (idx_r == 6'h29) begin
					o_busy <= 1'b0;
				end
			end
		end
	end
	// Open drain: only ever pulls the line dominant
	assign o_bus_tx_oe = o_busy && !o_lost && !sr_r[41];
endmodule : ieb_peer

// file: test/testbench.sv
`timescale 1ns/1ps
// Contest and listen checks against a second bus unit, then lone clip and abort checks
module testbench;
	import ieb_pkg::*;
	localparam int BP = 20; // Short bit period keeps the run brief
	localparam int IP = 60; // Idle span: longer than the two-bit released run in the peer's byte
	typedef struct packed {
		logic dbc;
		logic [11:0] da;
		logic pbc;
		logic [11:0] pa;
		logic win;
	} ieb_row_t;
	ieb_row_t rows [6] = '{'{1'b1, 12'hfff, 1'b0, 12'h000, 1'b1}, '{1'b0, 12'h000, 1'b1, 12'hfff, 1'b0},
		'{1'b0, 12'h123, 1'b0, 12'h124, 1'b1}, '{1'b0, 12'h124, 1'b0, 12'h123, 1'b0},
		'{1'b1, 12'h000, 1'b1, 12'hfff, 1'b1}, '{1'b1, 12'hfff, 1'b1, 12'h000, 1'b0}};
	logic clk, rst_n, req, bc, bvalid, abort, p_go, p_bc, p_oe, p_busy, p_lost, bus_n;
	logic tx_n, oe, rdy, master, lost, done, rxv, rxbc, ghit, uhit;
	logic [11:0] own, slv, p_ma, rxm, rxs;
	logic [5:0] len;
	logic [7:0] byt;
	logic [41:0] seen;
	int n_mismatch, checked, k, i, nrdy;
	ieb_row_t r;
	// Wired-AND line with a pull-up
	assign bus_n = (oe ? tx_n : 1'b1) & ~p_oe;
	ieb_arb #(.BIT_PERIOD(BP), .IDLE_PERIOD(IP)) i_ieb_arb (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_bus_rx_n(bus_n), .o_bus_tx_n(tx_n), .o_bus_tx_oe(oe), .i_tx_req(req), .i_tx_bcast(bc),
		.i_own_addr(own), .i_slave_addr(slv), .i_tx_len(len), .i_tx_byte(byt), .i_tx_byte_valid(bvalid),
		.o_tx_byte_ready(rdy), .i_abort(abort), .o_master(master), .o_lost(lost), .o_done(done),
		.o_rx_valid(rxv), .o_rx_bcast(rxbc), .o_rx_grp_hit(ghit), .o_rx_unit_hit(uhit),
		.o_rx_maddr(rxm), .o_rx_saddr(rxs));
	ieb_peer #(.BIT_PERIOD(BP)) i_ieb_peer (.i_core_clk(clk), .i_go(p_go), .i_bcast(p_bc), .i_maddr(p_ma),
		.i_saddr(own), .i_byte(8'h5a), .i_bus_rx_n(bus_n), .o_bus_tx_oe(p_oe), .o_busy(p_busy),
		.o_lost(p_lost), .o_seen(seen));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Bytes handed over
	always @(posedge clk) begin
		if (rdy === 1'b1 && bvalid) begin
			nrdy++;
		end
	end
	task automatic chk(input string nm, input logic [34:0] exp, input logic [34:0] got);
		checked++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	// Start a lone frame and wait for mastership
	task automatic solo(input logic [5:0] n);
		@(negedge clk);
		req = 1'b1;
		len = n;
		for (k = 0; k < 1000 && master !== 1'b1; k++) @(negedge clk);
	endtask : solo
	// Bounded wait for the design to finish, then a released gap
	task automatic settle();
		if (req) begin
			for (k = 0; k < 8000 && (p_busy || done !== 1'b1); k++) @(negedge clk);
			chk("done", 1, done);
		end
		req = 1'b0;
		for (k = 0; k < 2000 && p_busy; k++) @(negedge clk);
		repeat (3 * IP) @(negedge clk);
	endtask : settle
	initial begin
		{req, bc, abort, p_go, p_bc, n_mismatch, checked, nrdy} = '0;
		{own, slv, p_ma, len, byt} = '0;
		bvalid = 1'b1;
		rst_n = 1'b0;
		repeat (10) @(negedge clk);
		chk("oe_rst", 0, oe);
		chk("master_rst", 0, master);
		rst_n = 1'b1;
		repeat (3 * IP) @(negedge clk);
		$display("test reset done");
		// Contest table: both start at the same edge
		for (i = 0; i < 6; i++) begin
			r = rows[i];
			{bc, own, slv, len, byt, p_bc, p_ma} = {r.dbc, r.da, 12'h3a5, 6'h01, 8'hc6, r.pbc, r.pa};
			req = 1'b1;
			p_go = 1'b1;
			@(negedge clk);
			p_go = 1'b0;
			for (k = 0; k < 1000 && master !== 1'b1 && lost !== 1'b1; k++) @(negedge clk);
			chk("master", r.win, master);
			chk("lost", !r.win, lost);
			if (r.win) begin
				chk("tx_n", 0, tx_n);
				settle();
				chk("peer_lost", 1, p_lost);
				chk("frame", {~r.dbc, r.da, ^r.da, 12'h3a5, ^12'h3a5, 8'hc6}, seen[34:0]);
			end else begin
				req = 1'b0;
				for (k = 0; k < 1000 && rxv !== 1'b1; k++) @(negedge clk);
				chk("oe_rx", 0, oe);
				chk("rx_maddr", r.pa, rxm);
				chk("rx_bcast", r.pbc, rxbc);
				chk("hits", 3'b111, {rxv, ghit, uhit});
				chk("rx_saddr", r.da, rxs);
				settle();
				chk("peer_won", 0, p_lost);
			end
			$display("test contest row %0d done", i);
		end
		// Overlong count is clipped
		nrdy = 0;
		solo(6'h28);
		settle();
		chk("bytes", 32, nrdy);
		$display("test clip done");
		// Empty byte source at the first byte ends the frame without done
		bvalid = 1'b0;
		solo(6'h01);
		for (k = 0; k < 1000 && master === 1'b1; k++) @(negedge clk);
		chk("nobyte", 3'b000, {master, done, oe});
		req = 1'b0;
		bvalid = 1'b1;
		settle();
		$display("test empty source done");
		// Abort mid-frame, then stay quiet until idle
		solo(6'h02);
		abort = 1'b1;
		@(negedge clk);
		abort = 1'b0;
		@(negedge clk);
		chk("master_abort", 0, master);
		for (k = 0; k < IP - 4; k++) begin
			@(negedge clk);
			chk("oe_quiet", 0, oe);
		end
		req = 1'b0;
		$display("test abort done");
		conclude();
	end
	// Hang guard sized well above the whole sequence
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		conclude();
	end
endmodule : testbench
